/* src/srp_defs.vh */
// Timing counts, pin levels and buffer sizes shared by the serial ROM port.
`ifndef SRP_DEFS_VH
`define SRP_DEFS_VH
`define SRP_SYS_CLK_HZ 250000000
`define SRP_SLOW_HZ 30000000
`define SRP_FAST_HZ 60000000
`define SRP_HALF_SLOW ((`SRP_SYS_CLK_HZ + 2 * `SRP_SLOW_HZ - 1) / (2 * `SRP_SLOW_HZ))
`define SRP_HALF_FAST ((`SRP_SYS_CLK_HZ + 2 * `SRP_FAST_HZ - 1) / (2 * `SRP_FAST_HZ))
`define SRP_RATE_SLOW 1'h0
`define SRP_RATE_FAST 1'h1
`define SRP_BYTE_BITS 4'h8
`define SRP_FIFO_WIDTH 8
`define SRP_FIFO_DEPTH 16
`define SRP_FIFO_AW 4
`endif

/* src/srp_serial_rom_port.v */
// Serial ROM port master with rate strap capture, plus its receive FIFO.
//
// Summary of operation
// - Select output is active low; held high in power-down while the port is enabled.
// - Clock output is held low throughout chip reset.
// - During reset the data-out/strap pin floats with its weak pull-down on.
// - At reset release the strap level is captured, then the pin becomes data out.
// - Captured strap 0 selects the 30 MHz rate, 1 selects 60 MHz.
// - In suspend the data-out pin floats if strap was 1, else is driven low.
// - The data input keeps its weak pull-down enabled at all times.
`timescale 1ns/10ps
`include "srp_defs.vh"

module srp_fifo #(
  parameter WIDTH = `SRP_FIFO_WIDTH,
  parameter DEPTH = `SRP_FIFO_DEPTH,
  parameter AW = `SRP_FIFO_AW
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fill side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;
  reg [WIDTH-1:0] out_data_reg;
  reg out_valid_reg;
  wire do_write;
  wire do_read;

  // The output stage is a register so the drain side sees flop outputs.
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign do_write = in_valid && in_ready;
  assign do_read = (count_reg != {(AW+1){1'b0}}) && (!out_valid_reg || out_ready);
  assign out_data = out_data_reg;
  assign out_valid = out_valid_reg;

  always @* begin
    count_next = count_reg;
    if (do_write && !do_read) begin
      count_next = count_reg + {{AW{1'b0}}, 1'b1};
    end else if (do_read && !do_write) begin
      count_next = count_reg - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (do_write) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid_reg <= 1'b0;
      out_data_reg <= {WIDTH{1'b0}};
    end else begin
      count_reg <= count_next;
      if (do_write) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_read) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
        out_data_reg <= mem[rd_ptr_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule // srp_fifo

module srp_serial_rom_port (
  // Clock and chip reset
  input wire sys_clk,
  input wire rst,
  // Power and port control from chip logic
  input wire port_enable,
  input wire power_down,
  input wire suspend,
  // Frame request and transmit byte stream
  input wire frame_req,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  // Received byte stream
  output wire [7:0] rx_data,
  output wire rx_valid,
  input wire rx_ready,
  // Status
  output wire rate_fast,
  output wire busy,
  // ROM select and clock pins
  output wire rom_select_low,
  output wire general_pin_four,
  // Data-out pin that doubles as the rate strap
  input wire rom_rate_strap_in,
  output wire rom_rate_strap_out,
  output wire rom_rate_strap_oe_n,
  output wire rom_rate_strap_pull_en,
  // Data-in pin
  input wire rom_data_in,
  output wire rom_data_in_pull_en
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_LOAD = 5'h02;
  localparam [4:0] ST_SHIFT = 5'h04;
  localparam [4:0] ST_PUSH = 5'h08;
  localparam [4:0] ST_END = 5'h10;
  localparam integer HALF_SLOW = `SRP_HALF_SLOW;
  localparam integer HALF_FAST = `SRP_HALF_FAST;

  reg [4:0] state_reg;
  reg strap_meta_reg;
  reg strap_sync_reg;
  reg din_meta_reg;
  reg din_sync_reg;
  reg capture_pending_reg;
  reg rate_reg;
  reg [3:0] div_cnt_reg;
  reg tick_reg;
  reg [7:0] tx_shift_reg;
  reg [7:0] rx_shift_reg;
  reg [3:0] bit_cnt_reg;
  reg sel_low_reg;
  reg sclk_reg;
  reg dout_reg;
  reg pin_out_reg;
  reg pin_oe_n_reg;
  reg pin_pull_reg;
  reg din_pull_reg;
  reg tx_ready_reg;
  reg busy_reg;
  reg push_reg;
  wire fifo_in_ready;
  wire [3:0] half_count;
  wire stop_now;

  // Sample pins through two flops; they keep sampling during reset on purpose.
  always @(posedge sys_clk) begin
    strap_meta_reg <= rom_rate_strap_in;
    strap_sync_reg <= strap_meta_reg;
    din_meta_reg <= rom_data_in;
    din_sync_reg <= din_meta_reg;
  end

  // The reset pulse is far longer than the two synchroniser stages.
  always @(posedge sys_clk) begin
    if (rst) begin
      capture_pending_reg <= 1'b1;
      rate_reg <= `SRP_RATE_SLOW;
    end else if (capture_pending_reg) begin
      capture_pending_reg <= 1'b0;
      rate_reg <= strap_sync_reg;
    end
  end

  // Half-period counts round up, so the clock never exceeds the chosen rate.
  assign half_count = (rate_reg == `SRP_RATE_FAST) ? HALF_FAST[3:0] : HALF_SLOW[3:0];
  assign stop_now = !port_enable || power_down || suspend;

  // The divider restarts for every byte, so the first rising edge comes a full half period after the data.
  always @(posedge sys_clk) begin
    if (rst || (state_reg != ST_SHIFT && state_reg != ST_END)) begin
      div_cnt_reg <= 4'h1;
      tick_reg <= 1'b0;
    end else if (div_cnt_reg >= half_count) begin
      div_cnt_reg <= 4'h1;
      tick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
      tick_reg <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      sel_low_reg <= 1'b1;
      sclk_reg <= 1'b0;
      dout_reg <= 1'b0;
      tx_shift_reg <= 8'h00;
      rx_shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      tx_ready_reg <= 1'b0;
      push_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      push_reg <= 1'b0;
      if (stop_now || capture_pending_reg) begin
        // Leaving a frame mid-byte drops that byte; the ROM restarts on select.
        state_reg <= ST_IDLE;
        sel_low_reg <= 1'b1;
        sclk_reg <= 1'b0;
        tx_ready_reg <= 1'b0;
        busy_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sclk_reg <= 1'b0;
            if (frame_req) begin
              sel_low_reg <= 1'b0;
              busy_reg <= 1'b1;
              tx_ready_reg <= fifo_in_ready;
              state_reg <= ST_LOAD;
            end
          end
          ST_LOAD: begin
            if (!frame_req) begin
              tx_ready_reg <= 1'b0;
              state_reg <= ST_END;
            end else if (tx_valid && tx_ready_reg) begin
              tx_ready_reg <= 1'b0;
              tx_shift_reg <= {tx_data[6:0], 1'b0};
              dout_reg <= tx_data[7];
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_SHIFT;
            end else begin
              // A push still in flight is not yet in the count and would look like free room.
              tx_ready_reg <= fifo_in_ready && !push_reg;
            end
          end
          ST_SHIFT: begin
            if (tick_reg) begin
              if (!sclk_reg) begin
                sclk_reg <= 1'b1;
                rx_shift_reg <= {rx_shift_reg[6:0], din_sync_reg};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end else begin
                sclk_reg <= 1'b0;
                if (bit_cnt_reg == `SRP_BYTE_BITS) begin
                  state_reg <= ST_PUSH;
                end else begin
                  dout_reg <= tx_shift_reg[7];
                  tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                end
              end
            end
          end
          ST_PUSH: begin
            // Room was checked before the byte was taken, so this push never fails.
            push_reg <= 1'b1;
            state_reg <= ST_LOAD;
          end
          ST_END: begin
            if (tick_reg) begin
              sel_low_reg <= 1'b1;
              busy_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            sel_low_reg <= 1'b1;
            sclk_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // Shared pin: strap input in reset, suspend level while suspended, serial data output otherwise.
  always @(posedge sys_clk) begin
    if (rst || capture_pending_reg) begin
      pin_oe_n_reg <= 1'b1;
      pin_pull_reg <= 1'b1;
      pin_out_reg <= 1'b0;
    end else if (suspend) begin
      pin_pull_reg <= 1'b0;
      pin_out_reg <= 1'b0;
      pin_oe_n_reg <= (rate_reg == `SRP_RATE_FAST);
    end else begin
      pin_pull_reg <= 1'b0;
      pin_oe_n_reg <= 1'b0;
      pin_out_reg <= dout_reg;
    end
  end

  always @(posedge sys_clk) begin
    din_pull_reg <= 1'b1;
  end

  srp_fifo #(
    .WIDTH(`SRP_FIFO_WIDTH),
    .DEPTH(`SRP_FIFO_DEPTH),
    .AW(`SRP_FIFO_AW)
  ) u_rx_fifo (
    .clk(sys_clk),
    .rst(rst),
    .in_data(rx_shift_reg),
    .in_valid(push_reg),
    .in_ready(fifo_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  assign tx_ready = tx_ready_reg;
  assign rate_fast = rate_reg;
  assign busy = busy_reg;
  // The select flop holds the pin level itself, so the pin comes straight from a flop.
  assign rom_select_low = sel_low_reg;
  assign general_pin_four = sclk_reg;
  assign rom_rate_strap_out = pin_out_reg;
  assign rom_rate_strap_oe_n = pin_oe_n_reg;
  assign rom_rate_strap_pull_en = pin_pull_reg;
  assign rom_data_in_pull_en = din_pull_reg;
endmodule // srp_serial_rom_port

/* verif/srp_serial_rom_port_sva.sv */
// Concurrent checks on the serial ROM port pins.
`timescale 1ns/10ps
module srp_serial_rom_port_sva (
  // Clock, reset and power
  input wire sys_clk,
  input wire rst,
  input wire power_down,
  input wire suspend,
  // Pins and status
  input wire rate_fast,
  input wire rom_select_low,
  input wire general_pin_four,
  input wire rom_rate_strap_out,
  input wire rom_rate_strap_oe_n,
  input wire rom_rate_strap_pull_en,
  input wire rom_data_in_pull_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  reg rst_held_reg = 1'b0;
  // Reset checks start one edge into reset, once the flops have been cleared.
  always @(posedge sys_clk) rst_held_reg <= rst;
  // Reset checks watch the reset window itself, so they are never disabled.
  property p_clk_rst; disable iff (1'b0) rst && rst_held_reg |-> !general_pin_four; endproperty
  a_clk_rst: assert property (p_clk_rst) else $error("clock moved in reset");
  property p_pin_rst;
    disable iff (1'b0) rst && rst_held_reg |-> rom_rate_strap_oe_n && rom_rate_strap_pull_en;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("strap pin not floating");
  property p_pin_rel; $fell(rst) |-> ##2 ((!rom_rate_strap_oe_n && !rom_rate_strap_pull_en) || suspend); endproperty
  a_pin_rel: assert property (p_pin_rel) else $error("strap pin not released");
  property p_rate_hold; !$past(rst) && !$past(rst, 2) |-> $stable(rate_fast); endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate changed");
  property p_sel_pd; power_down && $past(power_down) |-> rom_select_low; endproperty
  a_sel_pd: assert property (p_sel_pd) else $error("select low in power-down");
  property p_clk_sel; rom_select_low |-> !general_pin_four; endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock while deselected");
  property p_fast_hi;
    disable iff (rst || power_down || suspend)
    rate_fast && $rose(general_pin_four) |-> general_pin_four [*3] ##1 !general_pin_four;
  endproperty
  a_fast_hi: assert property (p_fast_hi) else $error("fast half period");
  property p_slow_hi;
    disable iff (rst || power_down || suspend)
    !rate_fast && $rose(general_pin_four) |-> general_pin_four [*5] ##1 !general_pin_four;
  endproperty
  a_slow_hi: assert property (p_slow_hi) else $error("slow half period");
  property p_din_pull; rom_data_in_pull_en; endproperty
  a_din_pull: assert property (p_din_pull) else $error("data-in pull-down off");
  property p_susp;
    suspend && $past(suspend) |-> rom_rate_strap_oe_n == rate_fast && (rate_fast || !rom_rate_strap_out);
  endproperty
  a_susp: assert property (p_susp) else $error("data pin in suspend");
  c_fast: cover property (rate_fast && !rom_select_low);
  c_slow: cover property (!rate_fast && !rom_select_low);
  c_susp: cover property (suspend && rate_fast);
endmodule // srp_serial_rom_port_sva
bind srp_serial_rom_port srp_serial_rom_port_sva srp_serial_rom_port_sva_inst (
  .sys_clk(sys_clk),
  .rst(rst),
  .power_down(power_down),
  .suspend(suspend),
  .rate_fast(rate_fast),
  .rom_select_low(rom_select_low),
  .general_pin_four(general_pin_four),
  .rom_rate_strap_out(rom_rate_strap_out),
  .rom_rate_strap_oe_n(rom_rate_strap_oe_n),
  .rom_rate_strap_pull_en(rom_rate_strap_pull_en),
  .rom_data_in_pull_en(rom_data_in_pull_en)
);

/* verif/srp_rom_model.sv */
// Serial ROM stand-in that echoes the previous byte of a frame.
`timescale 1ns/10ps
module srp_rom_model (
  // Link pins
  input wire sel_n,
  input wire sck,
  input wire mosi,
  output reg miso = 1'b0
);
  reg [7:0] sr_reg = 8'h00;
  // Deselected, the shifter empties and the line falls to its pull-down level.
  always @(posedge sck or posedge sel_n) begin
    if (sel_n) sr_reg <= 8'h00;
    else sr_reg <= {sr_reg[6:0], mosi};
  end
  always @(negedge sck or posedge sel_n) begin
    if (sel_n) miso <= 1'b0;
    else miso <= sr_reg[7];
  end
endmodule // srp_rom_model

/* verif/srp_serial_rom_port_bench.sv */
// Self-checking bench for the serial ROM port.
`timescale 1ns/10ps
module srp_serial_rom_port_bench;
  reg sys_clk, rst = 1, power_down = 0, suspend = 0, frame_req = 0, tx_valid = 0, rx_ready = 0, strap_up = 0;
  reg port_enable = 1;
  wire busy;
  reg [7:0] tx_data = 8'h00, prev;
  wire [7:0] rx_data;
  wire rx_valid, tx_ready, rate_fast, sel_n, sck, dout, oe_n, din;
  integer fails = 0, tests_run = 0, n, k;
  // Strap resistor sets the level while the pin floats.
  wire pin = oe_n ? strap_up : dout;
  srp_serial_rom_port srp_serial_rom_port_inst (.sys_clk(sys_clk), .rst(rst), .port_enable(port_enable),
    .power_down(power_down), .suspend(suspend), .frame_req(frame_req), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rate_fast(rate_fast), .busy(busy), .rom_select_low(sel_n), .general_pin_four(sck), .rom_rate_strap_in(pin),
    .rom_rate_strap_out(dout), .rom_rate_strap_oe_n(oe_n), .rom_rate_strap_pull_en(), .rom_data_in(din),
    .rom_data_in_pull_en());
  srp_rom_model srp_rom_model_inst (.sel_n(sel_n), .sck(sck), .mosi(dout), .miso(din));
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task automatic cyc(input integer c);
    repeat (c) @(posedge sys_clk);
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task t_reset(input s, input integer c);
    begin
      strap_up <= s;
      rst <= 1;
      cyc(c);
      chk("clock", 8'h00, sck);
      chk("oe_n", 8'h01, oe_n);
      rst <= 0;
      cyc(4);
      chk("rate", s, rate_fast);
      chk("oe_n", 8'h00, oe_n);
      $display("test reset done");
    end
  endtask
  task t_frame;
    begin
      prev = 8'h00;
      frame_req <= 1;
      for (n = 0; n < 3; n = n + 1) begin
        tx_data <= 8'h5A + n;
        tx_valid <= 1;
        @(posedge sys_clk);
        while (!tx_ready) @(posedge sys_clk);
        tx_valid <= 0;
        while (!rx_valid) @(posedge sys_clk);
        chk("rx byte", prev, rx_data);
        chk("busy", 8'h01, busy);
        rx_ready <= 1;
        prev = 8'h5A + n;
        @(posedge sys_clk);
        rx_ready <= 0;
      end
      frame_req <= 0;
      $display("test frame done");
    end
  endtask
  // Far side does not drain until the fill stops, so the buffer must push back.
  task t_fill;
    begin
      // Let the previous frame close so the ROM starts a fresh echo.
      cyc(12);
      frame_req <= 1;
      tx_valid <= 1;
      tx_data <= 8'h00;
      n = 0;
      k = 0;
      while (k < 300) begin
        @(posedge sys_clk);
        k = k + 1;
        if (tx_ready) begin
          n = n + 1;
          k = 0;
          tx_data <= n[7:0];
        end
      end
      tx_valid <= 0;
      frame_req <= 0;
      chk("taken", 8'h11, n[7:0]);
      k = 0;
      rx_ready <= 1;
      repeat (40) begin
        @(posedge sys_clk);
        if (rx_valid) begin
          k = k + 1;
          chk("fill byte", (k < 2) ? 8'h00 : k - 2, rx_data);
        end
      end
      rx_ready <= 0;
      chk("drained", 8'h11, k[7:0]);
      chk("rx_valid", 8'h00, rx_valid);
      $display("test fill done");
    end
  endtask
  task t_low_power;
    begin
      power_down <= 1;
      cyc(3);
      chk("select", 8'h01, sel_n);
      chk("clock", 8'h00, sck);
      chk("busy", 8'h00, busy);
      power_down <= 0;
      suspend <= 1;
      cyc(3);
      chk("oe_n", strap_up, oe_n);
      if (!strap_up) chk("dout", 8'h00, dout);
      suspend <= 0;
      port_enable <= 0;
      frame_req <= 1;
      cyc(4);
      chk("select", 8'h01, sel_n);
      chk("busy", 8'h00, busy);
      frame_req <= 0;
      port_enable <= 1;
      cyc(3);
      $display("test low power done");
    end
  endtask
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    cyc(30000);
    fails = fails + 1;
    stop_test;
  end
  initial begin
    t_reset(0, 6);
    t_frame;
    t_low_power;
    t_reset(1, 250);
    t_frame;
    t_fill;
    t_low_power;
    stop_test;
  end
endmodule // srp_serial_rom_port_bench
